/* logic/adcc_map.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  conversion control block. Assumes byte addressing on an 8-bit AXI4-Lite
  address, one aligned 32-bit word per register.
*/
// Behaviour
// - Each conversion lasts exactly 40 machine cycles from start to completion flag.
// - One of five inputs is chosen by the selector; each conversion yields 8 bits.
// - Control bits 2..0 are a binary channel code; 000..100 pick inputs 0..4.
// - Channel code may change only while start bit and completion flag are low.
// - With the converter disabled, the five analog pins act as plain digital pins.
// - Completion flag, control bit 4, is set when a conversion finishes.
// - Interrupt request while completion flag, converter interrupt enable and global interrupt enable are all 1.
// - Completion flag is read-only and clears when the result is read.
// - Writing 1 to control bit 3 starts a conversion; bit stays high throughout.
// - Only completion or entry into idle or power-down clears the start bit; software writes of 0 do nothing.
// - Flag/start pair: 00 idle, 01 busy, 10 result waiting; start only in 00.
// - Start requests while busy or result waiting are dropped, never queued.
// - A start during a running conversion does not restart or disturb it.
// - Result register holds the finished value unchanged while the flag is 1.
// - Entering idle or power-down aborts a running conversion.
// - A waiting result and its flag survive entry into idle mode.
// - While enabled, a digital read of the selected analog pin returns 1.
// - Control register sits at address a0, result register at 84.
// - No interrupt request while the global interrupt enable bit 7 is 0.
// - One machine cycle equals twelve oscillator periods.
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Byte offsets
`define ADCC_OFS_RESULT   8'h84
`define ADCC_OFS_CONTROL  8'ha0
`define ADCC_OFS_IRQ_EN   8'ha8
`define ADCC_OFS_PORT     8'h90
`define ADCC_OFS_POWER    8'hb4

// Control fields
`define ADCC_CTL_ENABLE   5
`define ADCC_CTL_FLAG     4
`define ADCC_CTL_START    3
`define ADCC_CTL_CHAN_HI  2
// Interrupt enable fields
`define ADCC_IE_GLOBAL    7
`define ADCC_IE_CONV      6
// Power fields
`define ADCC_PWR_IDLE     0
`define ADCC_PWR_DOWN     1

// Reset values
`define ADCC_RST_PORT     5'h1f
`define ADCC_RST_CHAN     3'h0
`define ADCC_RST_RESULT   8'h00

// Timing: machine cycles per conversion, oscillator periods per machine cycle
`define ADCC_CONV_MC      40
`define ADCC_OSC_PER_MC   12
`define ADCC_DIV_LAST     (`ADCC_OSC_PER_MC - 1)
`define ADCC_MC_LAST      (`ADCC_CONV_MC - 1)

// AXI responses
`define ADCC_RESP_OKAY    2'h0
`define ADCC_RESP_SLVERR  2'h2

`endif

/* logic/adcc_pkg.sv */
/*
  Types of the conversion control block: the packed state record.
  Assumes adcc_map.svh supplies the numeric constants.
*/
package adcc_pkg;

  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       aw_held;
    logic       w_held;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic       wlane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic       enable;
    logic       flag;
    logic       start;
    logic [2:0] chan;
    logic [7:0] result;
    logic [3:0] div;
    logic [5:0] mcnt;
    logic       ie_conv;
    logic       ie_global;
    logic       idle;
    logic       pdown;
    logic [4:0] port_latch;
    logic       irq;
    logic       sample;
    logic [4:0] pin_oe;
  } adcc_state_s;

endpackage

/* logic/adcc_conv_ctrl.sv */
/*
  Conversion control block: control and result registers, machine cycle
  divider, conversion timing, interrupt request and analog pin digital view,
  all behind an AXI4-Lite slave. Assumes an external converter presents its
  8-bit answer for the channel on chan_sel_o at conv_data_i, and that every
  input is synchronous to mclk_i.
*/
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "adcc_map.svh"

module adcc_conv_ctrl
  import adcc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [7:0]  conv_data_i,
  output logic [2:0]       chan_sel_o,
  output logic             sample_o,
  output logic             irq_o,
  input  wire logic [4:0]  pin_i,
  output logic [4:0]       pin_o,
  output logic [4:0]       pin_oe_o
);

  adcc_state_s st;
  adcc_state_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Known register word, shared by the read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == `ADCC_OFS_RESULT) || (w == `ADCC_OFS_CONTROL) ||
           (w == `ADCC_OFS_IRQ_EN) || (w == `ADCC_OFS_PORT) ||
           (w == `ADCC_OFS_POWER);
  endfunction

  // Same word as a given offset, low address bits ignored
  function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
    return {a[7:2], 2'b00} == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic       idle_now;
    logic [4:0] pin_view;
    logic [7:0] rd;
    logic [7:0] wd;
    logic       conv_done;
    idle_now  = 1'b0;
    pin_view  = 5'h00;
    rd        = 8'h00;
    wd        = 8'h00;
    conv_done = 1'b0;
    next_st   = st;
    next_st.sample = 1'b0;

    // Flag/start pair 00 means ready for a new start or a channel change
    idle_now = !st.flag && !st.start;

    // Digital view of the analog pins; selected pin reads 1 while enabled
    pin_view = pin_i;
    if (st.enable && (st.chan <= 3'h4))
    begin
      pin_view[st.chan] = 1'b1;
    end

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid_i && st.awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.waddr   = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st.wready)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata_i[7:0];
      next_st.wlane0 = s_axi_wstrb_i[0];
    end
    if (st.bvalid && s_axi_bready_i)
    begin
      next_st.bvalid = 1'b0;
    end

    // Perform a write once both halves are held and no response is pending
    if (st.aw_held && st.w_held && !st.bvalid)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = is_mapped(st.waddr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      wd = st.wdata;
      // Only lane 0 carries register bits; other lanes are ignored
      if (st.wlane0)
      begin
        if (hits(st.waddr, `ADCC_OFS_CONTROL))
        begin
          next_st.enable = wd[`ADCC_CTL_ENABLE];
          // Channel code locked unless ready; software must also respect this
          if (idle_now)
          begin
            next_st.chan = wd[`ADCC_CTL_CHAN_HI:0];
          end
          // Start only from 00, enabled and awake; other requests are lost
          if (wd[`ADCC_CTL_START] && idle_now && wd[`ADCC_CTL_ENABLE] &&
              !st.idle && !st.pdown)
          begin
            next_st.start  = 1'b1;
            next_st.div    = 4'h0;
            next_st.mcnt   = 6'h00;
            next_st.sample = 1'b1;
          end
          // Writing 0 to start and anything to the flag has no effect
        end
        if (hits(st.waddr, `ADCC_OFS_IRQ_EN))
        begin
          next_st.ie_conv   = wd[`ADCC_IE_CONV];
          next_st.ie_global = wd[`ADCC_IE_GLOBAL];
        end
        if (hits(st.waddr, `ADCC_OFS_PORT))
        begin
          next_st.port_latch = wd[4:0];
        end
        if (hits(st.waddr, `ADCC_OFS_POWER))
        begin
          next_st.idle  = wd[`ADCC_PWR_IDLE];
          next_st.pdown = wd[`ADCC_PWR_DOWN];
        end
      end
    end

    // Read path: one outstanding read, data captured at the address edge
    if (st.rvalid && s_axi_rready_i)
    begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st.arready)
    begin
      if (hits(s_axi_araddr_i, `ADCC_OFS_RESULT))
      begin
        rd = st.result;
        // Reading the result releases the waiting state
        next_st.flag = 1'b0;
      end
      else if (hits(s_axi_araddr_i, `ADCC_OFS_CONTROL))
      begin
        rd = {2'b00, st.enable, st.flag, st.start, st.chan};
      end
      else if (hits(s_axi_araddr_i, `ADCC_OFS_IRQ_EN))
      begin
        rd = {st.ie_global, st.ie_conv, 6'h00};
      end
      else if (hits(s_axi_araddr_i, `ADCC_OFS_PORT))
      begin
        rd = {3'h0, pin_view};
      end
      else if (hits(s_axi_araddr_i, `ADCC_OFS_POWER))
      begin
        rd = {6'h00, st.pdown, st.idle};
      end
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = is_mapped(s_axi_araddr_i) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end

    // Machine cycle divider and conversion counter run only while busy
    if (st.start)
    begin
      if (st.div == 4'(`ADCC_DIV_LAST))
      begin
        next_st.div = 4'h0;
        if (st.mcnt == 6'(`ADCC_MC_LAST))
        begin
          conv_done = 1'b1;
        end
        else
        begin
          next_st.mcnt = st.mcnt + 6'h01;
        end
      end
      else
      begin
        next_st.div = st.div + 4'h1;
      end
    end

    // Sleep modes abort a conversion but keep a waiting result intact
    if (next_st.idle || next_st.pdown)
    begin
      next_st.start = 1'b0;
      next_st.div   = 4'h0;
      next_st.mcnt  = 6'h00;
    end
    else if (conv_done)
    begin
      // Start drops in the same edge the flag rises; set wins over clear
      next_st.start  = 1'b0;
      next_st.flag   = 1'b1;
      next_st.result = conv_data_i;
    end

    // Ready lines follow what is held
    next_st.awready = !next_st.aw_held;
    next_st.wready  = !next_st.w_held;
    next_st.arready = !next_st.rvalid;

    // Interrupt request gated by both enables
    next_st.irq = next_st.flag && next_st.ie_conv && next_st.ie_global;

    // Analog pins float while enabled; otherwise open drain from the latch
    next_st.pin_oe = next_st.enable ? 5'h00 : ~next_st.port_latch;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st            <= '0;
      st.awready    <= 1'b1;
      st.wready     <= 1'b1;
      st.arready    <= 1'b1;
      st.chan       <= `ADCC_RST_CHAN;
      st.result     <= `ADCC_RST_RESULT;
      st.port_latch <= `ADCC_RST_PORT;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register, except pin_o, which is tied to 0

  assign s_axi_awready_o = st.awready;
  assign s_axi_wready_o  = st.wready;
  assign s_axi_bvalid_o  = st.bvalid;
  assign s_axi_bresp_o   = st.bresp;
  assign s_axi_arready_o = st.arready;
  assign s_axi_rvalid_o  = st.rvalid;
  assign s_axi_rdata_o   = {24'h000000, st.rdata};
  assign s_axi_rresp_o   = st.rresp;
  assign chan_sel_o      = st.chan;
  assign sample_o        = st.sample;
  assign irq_o           = st.irq;
  assign pin_o           = 5'h00; // Open drain: only ever pulls low
  assign pin_oe_o        = st.pin_oe;

endmodule // adcc_conv_ctrl

/* test/adcc_conv_ctrl_assertions.sv */
/* Checker for the conversion control block: bus answers, start pulse and pin
   release. Sees only top ports; bound from the bench top. */
`timescale 1ns/1ps
module adcc_conv_chk (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        sample_o,
  input wire logic        irq_o,
  input wire logic [2:0]  chan_sel_o,
  input wire logic [4:0]  pin_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // Answers stand until the master takes them
  rd_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer changed early");
  wr_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer changed early");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered next cycle");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("address taken while answer pending");
  // A conversion is not restarted in the 8 cycles after its start
  start_once_a: assert property (sample_o |=> !sample_o [*8])
    else $error("conversion restarted");
  chan_lock_a: assert property (sample_o |=> $stable(chan_sel_o) [*8])
    else $error("channel moved during conversion");
  no_early_irq_a: assert property (sample_o |-> !irq_o [*8])
    else $error("request before completion");
  pins_free_a: assert property (sample_o |-> pin_oe_o == 5'h00)
    else $error("pin driven while converting");
endmodule // adcc_conv_chk

/* test/adcc_analog_model.sv */
/* Far side model: converter answer per channel and open drain pin wires.
   Assumes the bench supplies the outside pin levels. */
`timescale 1ns/1ps
module adcc_analog_model (
  input  wire logic [2:0] chan_i,
  input  wire logic [4:0] oe_i,
  input  wire logic [4:0] ext_i,
  output logic      [7:0] conv_o,
  output logic      [4:0] lvl_o
);
  ////////////////////////////////////////
  // Each channel answers its own code, so a wrong mux choice shows
  assign conv_o = {chan_i, 5'h15};
  // An enabled driver pulls low; otherwise the outside level wins
  assign lvl_o = ext_i & ~oe_i;
endmodule // adcc_analog_model

/* test/adcc_conv_ctrl_tb.sv */
/* Bench top: drives the block over AXI4-Lite, notes expected answers in
   queues and checks them as they appear. Assumes the analog model. */
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_conv_ctrl_tb;
  localparam logic [7:0] a_ctl = `ADCC_OFS_CONTROL;
  localparam logic [7:0] a_res = `ADCC_OFS_RESULT;
  localparam logic [7:0] a_ie  = `ADCC_OFS_IRQ_EN;
  localparam logic [7:0] a_prt = `ADCC_OFS_PORT;
  localparam logic [7:0] a_pwr = `ADCC_OFS_POWER;
  localparam logic [1:0] ok    = `ADCC_RESP_OKAY;
  localparam logic [1:0] err   = `ADCC_RESP_SLVERR;
  logic        mclk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i;
  logic        s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, sample_o, irq_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, conv_data_i, seed;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [2:0]  chan_sel_o;
  logic [4:0]  pin_i, pin_o, pin_oe_o, ext;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          failures = 0, n_tests = 0, cyc = 0, t_b, k, ch;
  logic        lazy = 1'b0; // Master leaves an answer waiting one cycle
  adcc_conv_ctrl dut (.*);
  adcc_analog_model far (.chan_i(chan_sel_o), .oe_i(pin_oe_o), .ext_i(ext),
                         .conv_o(conv_data_i), .lvl_o(pin_i));
  ////////////////////////////////////////
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Offers address and data together; bready is up until answered, or raised only after the answer when lazy
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h000000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= !lazy;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    t_b = cyc;
    // A lazy master takes the standing answer one edge later
    if (lazy)
    begin
      s_axi_bready_i <= 1'b1;
      @(posedge mclk_i);
    end
    s_axi_bready_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h000000, d});
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= !lazy;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    // The read answer must stand until the late rready arrives
    if (lazy)
    begin
      s_axi_rready_i <= 1'b1;
      @(posedge mclk_i);
    end
    s_axi_rready_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // One conversion with refused requests, masking on channel 3 and idle on channel 4 along the way
  task automatic conv(input logic [2:0] c);
    logic [2:0] n;
    int         t0;
    n = (c == 3'h4) ? 3'h0 : c + 3'h1;
    seed = lfsr(seed);
    ext <= seed[4:0];
    wr(a_ctl, {5'h05, c}, ok);
    t0 = t_b;
    rd(a_ctl, {5'h05, c}, ok);
    rd(a_prt, {3'h0, seed[4:0] | (5'h01 << c)}, ok);
    wr(a_ctl, {5'h04, n}, ok);
    rd(a_ctl, {5'h05, c}, ok);
    wr(a_ctl, {5'h05, n}, ok);
    k = 0;
    while (!irq_o && k < 700)
    begin
      @(posedge mclk_i);
      k++;
    end
    // Write answer and request both show one edge after their cause
    chk(34'(`ADCC_CONV_MC * `ADCC_OSC_PER_MC), 34'(cyc - t0));
    if (c == 3'h3)
    begin
      wr(a_ie, 8'h40, ok);
      chk(34'h0, {33'h0, irq_o});
      wr(a_ie, 8'hc0, ok);
    end
    if (c == 3'h4) wr(a_pwr, 8'h01, ok);
    wr(a_ctl, {5'h04, n}, ok);
    rd(a_ctl, {5'h06, c}, ok);
    rd(a_res, {c, 5'h15}, ok);
    rd(a_ctl, {5'h04, c}, ok);
    if (c == 3'h4) wr(a_pwr, 8'h00, ok);
    $display("test channel %0d done", c);
  endtask
  // Notes are matched as answers appear; a hang ends the run
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk(rq.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk({32'h0, bq.pop_front()}, {32'h0, s_axi_bresp_o});
    if (cyc == 8000)
    begin
      failures++;
      end_of_test;
    end
  end
  initial
  begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
    s_axi_wstrb_i = 4'hf;
    ext = 5'h00;
    seed = 8'h0b;
    rst_n_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(a_ctl, 8'h00, ok);
    rd(a_res, 8'h00, ok);
    // Unmapped accesses also check that answers stand while not taken
    lazy = 1'b1;
    rd(8'h10, 8'h00, err);
    wr(8'h10, 8'hff, err);
    lazy = 1'b0;
    wr(a_ctl, 8'h0c, ok);
    rd(a_ctl, 8'h04, ok);
    seed = lfsr(seed);
    ext <= seed[4:0];
    wr(a_prt, 8'h1a, ok);
    rd(a_prt, {3'h0, seed[4:0] & 5'h1a}, ok);
    $display("test reset and port done");
    wr(a_ie, 8'hc0, ok);
    for (ch = 0; ch < 5; ch++) conv(ch[2:0]);
    // Power-down in mid conversion: start drops and no result follows
    wr(a_ctl, 8'h29, ok);
    wr(a_pwr, 8'h02, ok);
    rd(a_ctl, 8'h21, ok);
    wr(a_pwr, 8'h00, ok);
    repeat (500) @(posedge mclk_i);
    chk(34'h0, {33'h0, irq_o});
    $display("test abort done");
    end_of_test;
  end
endmodule // adcc_conv_ctrl_tb
bind adcc_conv_ctrl adcc_conv_chk chk (.*);
